// file: sgpw_pkg.sv
// Shared constants for the serial gray-scale pixel RAM writer
package sgpw_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BYTE_BITS     = 8;
  localparam logic [2:0]  BIT_MSB       = 3'h7;
  localparam logic [7:0]  CMD_SET_COL   = 8'h15;
  localparam logic [7:0]  CMD_SET_ROW   = 8'h75;
  localparam logic [7:0]  CMD_MAP_NORM  = 8'ha0;
  localparam logic [7:0]  CMD_MAP_ROT   = 8'ha1;
  localparam int unsigned COL_W         = 6;
  localparam int unsigned ROW_W         = 7;
  localparam int unsigned ADDR_W        = 13;
  localparam logic [5:0]  COL_START_POR = 6'h00;
  localparam logic [5:0]  COL_END_POR   = 6'h3f;
  localparam logic [6:0]  ROW_START_POR = 7'h00;
  localparam logic [6:0]  ROW_END_POR   = 7'h4f;
  localparam logic [5:0]  COL_MASK      = 6'h3f;
  localparam logic [6:0]  ROW_MASK      = 7'h7f;
  localparam int unsigned ROW_SHIFT     = 6;
  localparam logic [12:0] ADDR_LAST     = 13'h13ff;
  localparam int unsigned PIXEL_BITS    = 4;
endpackage

// file: sgpw_link_rx.sv
// Link-clock side shift register: assembles bytes on falling serial clock edges
`timescale 1ns/100ps
`default_nettype none
module sgpw_link_rx (
  // Link clock and framing
  input  wire logic       link_clk,
  input  wire logic       select_n,
  input  wire logic       serial_data_line,
  input  wire logic       data_cmd,
  // Byte out, held stable while the valid flag is up
  output logic [7:0]      byte_reg,
  output logic            byte_dc_reg,
  output logic            byte_vld_reg
);
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;

  // Select high resets the bit count asynchronously to the link clock, since
  // the link clock stands still outside frames and a partial byte must drop.
  always_ff @(negedge link_clk or posedge select_n) begin
    if (select_n) begin
      bit_cnt_reg  <= sgpw_pkg::BIT_MSB;
      shift_reg    <= 7'h00;
      byte_vld_reg <= 1'b0;
    end else begin
      shift_reg    <= {shift_reg[5:0], serial_data_line};
      bit_cnt_reg  <= bit_cnt_reg - 3'h1;
      // Flag drops on the next bit or on deselect: a link period must span 3 system clocks
      byte_vld_reg <= (bit_cnt_reg == 3'h0);
    end
  end

  always_ff @(negedge link_clk) begin
    if (!select_n && bit_cnt_reg == 3'h0) begin
      byte_reg     <= {shift_reg, serial_data_line};
      byte_dc_reg  <= data_cmd;
    end
  end
endmodule
`default_nettype wire

// file: sgpw_top.sv
// Serial gray-scale pixel RAM writer: link receive, command decode, pixel memory
// Functional notes
// - Link has data/command, select, data, clock and reset pins.
// - Bytes are eight bits, most significant bit first.
// - Host changes data on rising clock; device samples on falling.
// - Data/command level routes byte to pixel memory or commands.
// - Four-bit gray pixel, two adjacent pixels per byte.
// - Bits 7:4 even column, 3:0 odd column; rows are 64 bytes.
// - Full image 5120 bytes; byte columns 0 to 63.
// - Pointer advances after every data byte.
// - Pointer stays inside the programmed column/row window.
// - Host may program a sub-window and send only its bytes.
// - Port is write-only; nothing is read back.
// - Stored content is displayed without host refresh.
// - Alternative mapping rotates output 180 degrees.
// - Command 0x15 then start, end sets column window; POR 0 and 63.
// - Command 0x75 then start, end sets row window; POR 0 and 79.
`timescale 1ns/100ps
`default_nettype none
module sgpw_top (
  // System clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Serial link from host
  input  wire logic        link_clk,
  input  wire logic        select_n,
  input  wire logic        data_cmd,
  input  wire logic        serial_data_line,
  input  wire logic        reset_n,
  input  wire logic        interface_strap_0,
  input  wire logic        interface_strap_1,
  // Display scan port
  input  wire logic [12:0] scan_addr,
  output logic [7:0]       scan_data_reg,
  // Status
  output logic             serial_mode_reg,
  output logic             rotate_reg,
  output logic [12:0]      wr_addr_reg
);
  logic [7:0] rx_byte;
  logic       rx_dc;
  logic       rx_vld;
  logic [2:0] vld_sync_reg;
  logic [2:0] rstn_sync_reg;
  logic [2:0] strap_sync_reg;
  logic       rst_pin_reg;
  logic       byte_stb;
  logic       soft_rst;

  // Link domain shifter; select also gates this module's use of the clock
  sgpw_link_rx u_rx (
    .link_clk         (link_clk),
    .select_n         (select_n | ~reset_n),
    .serial_data_line (serial_data_line),
    .data_cmd         (data_cmd),
    .byte_reg         (rx_byte),
    .byte_dc_reg      (rx_dc),
    .byte_vld_reg     (rx_vld)
  );

  // Three-stage synchronisers; reset and strap changes counted when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vld_sync_reg   <= 3'h0;
      rstn_sync_reg  <= 3'h0;
      strap_sync_reg <= 3'h0;
    end else begin
      vld_sync_reg   <= {vld_sync_reg[1:0], rx_vld};
      rstn_sync_reg  <= {rstn_sync_reg[1:0], reset_n};
      strap_sync_reg <= {strap_sync_reg[1:0], ~(interface_strap_0 | interface_strap_1)};
    end
  end

  // Valid rise seen between stage 2 and 3; byte data is stable by then
  assign byte_stb = vld_sync_reg[1] & ~vld_sync_reg[2];
  assign soft_rst = sys_rst | rst_pin_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rst_pin_reg     <= 1'b0;
      serial_mode_reg <= 1'b0;
    end else begin
      if (rstn_sync_reg[2] == rstn_sync_reg[1]) begin
        rst_pin_reg <= ~rstn_sync_reg[2];
      end
      if (strap_sync_reg[2] == strap_sync_reg[1]) begin
        serial_mode_reg <= strap_sync_reg[2];
      end
    end
  end

  // Command decoder state
  typedef enum {SGPW_IDLE, SGPW_COL_A, SGPW_COL_B, SGPW_ROW_A, SGPW_ROW_B} sgpw_state_t;
  sgpw_state_t state_reg;
  logic [5:0]  col_start_reg;
  logic [5:0]  col_end_reg;
  logic [6:0]  row_start_reg;
  logic [6:0]  row_end_reg;
  logic [5:0]  col_ptr_reg;
  logic [6:0]  row_ptr_reg;
  logic        cmd_stb;
  logic        data_stb;

  assign cmd_stb  = byte_stb && !rx_dc;
  assign data_stb = byte_stb && rx_dc;

  always_ff @(posedge ref_clk) begin
    if (soft_rst) begin
      state_reg     <= SGPW_IDLE;
      col_start_reg <= sgpw_pkg::COL_START_POR;
      col_end_reg   <= sgpw_pkg::COL_END_POR;
      row_start_reg <= sgpw_pkg::ROW_START_POR;
      row_end_reg   <= sgpw_pkg::ROW_END_POR;
      rotate_reg    <= 1'b0;
    end else if (cmd_stb) begin
      case (state_reg)
        SGPW_IDLE: begin
          if (rx_byte == sgpw_pkg::CMD_SET_COL) begin
            state_reg <= SGPW_COL_A;
          end else if (rx_byte == sgpw_pkg::CMD_SET_ROW) begin
            state_reg <= SGPW_ROW_A;
          end else if (rx_byte == sgpw_pkg::CMD_MAP_ROT) begin
            rotate_reg <= 1'b1;
          end else if (rx_byte == sgpw_pkg::CMD_MAP_NORM) begin
            rotate_reg <= 1'b0;
          end
        end
        SGPW_COL_A: begin
          col_start_reg <= rx_byte[5:0] & sgpw_pkg::COL_MASK;
          state_reg     <= SGPW_COL_B;
        end
        SGPW_COL_B: begin
          col_end_reg <= rx_byte[5:0] & sgpw_pkg::COL_MASK;
          state_reg   <= SGPW_IDLE;
        end
        SGPW_ROW_A: begin
          row_start_reg <= rx_byte[6:0] & sgpw_pkg::ROW_MASK;
          state_reg     <= SGPW_ROW_B;
        end
        SGPW_ROW_B: begin
          row_end_reg <= rx_byte[6:0] & sgpw_pkg::ROW_MASK;
          state_reg   <= SGPW_IDLE;
        end
        default: begin
          state_reg <= SGPW_IDLE;
        end
      endcase
    end
  end

  // Pointer: loads on start byte, advances per data byte inside the window
  always_ff @(posedge ref_clk) begin
    if (soft_rst) begin
      col_ptr_reg <= sgpw_pkg::COL_START_POR;
      row_ptr_reg <= sgpw_pkg::ROW_START_POR;
    end else if (cmd_stb && state_reg == SGPW_COL_A) begin
      col_ptr_reg <= rx_byte[5:0];
    end else if (cmd_stb && state_reg == SGPW_ROW_A) begin
      row_ptr_reg <= rx_byte[6:0];
    end else if (data_stb) begin
      if (col_ptr_reg == col_end_reg) begin
        col_ptr_reg <= col_start_reg;
        if (row_ptr_reg == row_end_reg) begin
          row_ptr_reg <= row_start_reg;
        end else begin
          row_ptr_reg <= row_ptr_reg + 7'h01;
        end
      end else begin
        col_ptr_reg <= col_ptr_reg + 6'h01;
      end
    end
  end

  // Byte address: row times 64 plus byte column
  logic [12:0] ptr_addr;
  assign ptr_addr = {row_ptr_reg, col_ptr_reg};

  always_ff @(posedge ref_clk) begin
    if (soft_rst) begin
      wr_addr_reg <= 13'h0000;
    end else begin
      wr_addr_reg <= ptr_addr;
    end
  end

  // Pixel memory held in flip-flops; covers the full row range.
  // Not cleared by reset: image persists without refresh.
  localparam int unsigned MEM_DEPTH = 5120;
  logic [7:0] mem [MEM_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (data_stb && !soft_rst && ptr_addr <= sgpw_pkg::ADDR_LAST) begin
      mem[ptr_addr] <= rx_byte;
    end
  end

  // Scan read: rotation reverses address and swaps nibbles so pixel order flips
  logic [12:0] rd_addr;
  logic [7:0]  rd_byte;
  assign rd_addr = rotate_reg ? (sgpw_pkg::ADDR_LAST - scan_addr) : scan_addr;
  assign rd_byte = (rd_addr <= sgpw_pkg::ADDR_LAST) ? mem[rd_addr] : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scan_data_reg <= 8'h00;
    end else if (rotate_reg) begin
      scan_data_reg <= {rd_byte[3:0], rd_byte[7:4]};
    end else begin
      scan_data_reg <= rd_byte;
    end
  end

  // Write-only: no path returns memory content to the link

  chk_ptr_wrap_col : assert property (@(posedge ref_clk) disable iff (soft_rst)
    data_stb && col_ptr_reg == col_end_reg |=> col_ptr_reg == col_start_reg)
    else $error("column pointer did not wrap to start");
  chk_ptr_step : assert property (@(posedge ref_clk) disable iff (soft_rst)
    data_stb && col_ptr_reg != col_end_reg |=> col_ptr_reg == $past(col_ptr_reg) + 6'h01)
    else $error("column pointer did not advance");
  chk_row_wrap : assert property (@(posedge ref_clk) disable iff (soft_rst)
    data_stb && col_ptr_reg == col_end_reg && row_ptr_reg == row_end_reg
    |=> row_ptr_reg == row_start_reg)
    else $error("row pointer did not wrap");
  chk_row_step : assert property (@(posedge ref_clk) disable iff (soft_rst)
    data_stb && col_ptr_reg == col_end_reg && row_ptr_reg != row_end_reg
    |=> row_ptr_reg == $past(row_ptr_reg) + 7'h01)
    else $error("row pointer did not step to the next row");
  chk_row_hold : assert property (@(posedge ref_clk) disable iff (soft_rst)
    data_stb && col_ptr_reg != col_end_reg |=> $stable(row_ptr_reg))
    else $error("row pointer moved inside a row");
  chk_col_load : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_COL_A |=> col_ptr_reg == col_start_reg)
    else $error("column pointer not loaded from start");
  chk_row_load : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_ROW_A |=> row_ptr_reg == row_start_reg)
    else $error("row pointer not loaded from start");
  chk_cmd_no_move : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_IDLE |=> $stable(col_ptr_reg) && $stable(row_ptr_reg))
    else $error("command byte moved pointer");
  chk_end_no_move : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && (state_reg == SGPW_COL_B || state_reg == SGPW_ROW_B)
    |=> $stable(col_ptr_reg) && $stable(row_ptr_reg))
    else $error("window end byte moved pointer");
  chk_addr_map : assert property (@(posedge ref_clk) disable iff (soft_rst)
    1'b1 |=> wr_addr_reg == $past(row_ptr_reg) * 64 + $past(col_ptr_reg))
    else $error("byte address mapping wrong");

  // Decoder and memory write checks
  chk_col_start_load : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_COL_A |=> col_start_reg == $past(rx_byte[5:0]))
    else $error("column start not taken");
  chk_col_end_load : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_COL_B |=> col_end_reg == $past(rx_byte[5:0]))
    else $error("column end not taken");
  chk_row_start_load : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_ROW_A |=> row_start_reg == $past(rx_byte[6:0]))
    else $error("row start not taken");
  chk_row_end_load : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_ROW_B |=> row_end_reg == $past(rx_byte[6:0]))
    else $error("row end not taken");
  chk_col_seq : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_COL_A |=> state_reg == SGPW_COL_B)
    else $error("column command did not wait for end byte");
  chk_row_seq : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_ROW_A |=> state_reg == SGPW_ROW_B)
    else $error("row command did not wait for end byte");
  chk_win_done : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && (state_reg == SGPW_COL_B || state_reg == SGPW_ROW_B)
    |=> state_reg == SGPW_IDLE)
    else $error("decoder did not return to idle");
  chk_rot_set : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_IDLE && rx_byte == sgpw_pkg::CMD_MAP_ROT
    |=> rotate_reg)
    else $error("rotated mapping not selected");
  chk_rot_clear : assert property (@(posedge ref_clk) disable iff (soft_rst)
    cmd_stb && state_reg == SGPW_IDLE && rx_byte == sgpw_pkg::CMD_MAP_NORM
    |=> !rotate_reg)
    else $error("normal mapping not selected");
  chk_data_no_cmd : assert property (@(posedge ref_clk) disable iff (soft_rst)
    data_stb |=> $stable(state_reg) && $stable(rotate_reg))
    else $error("data byte reached the command decoder");
  chk_mem_write : assert property (@(posedge ref_clk) disable iff (soft_rst)
    data_stb && ptr_addr <= sgpw_pkg::ADDR_LAST
    |=> mem[$past(ptr_addr)] == $past(rx_byte))
    else $error("data byte not stored at pointer");

  // Reset checks
  chk_por_window : assert property (@(posedge ref_clk)
    soft_rst |=> col_end_reg == sgpw_pkg::COL_END_POR && row_end_reg == sgpw_pkg::ROW_END_POR)
    else $error("window not restored by reset");
  chk_rst_ptr : assert property (@(posedge ref_clk)
    soft_rst |=> col_ptr_reg == sgpw_pkg::COL_START_POR
    && row_ptr_reg == sgpw_pkg::ROW_START_POR)
    else $error("pointer not restored by reset");
  chk_rst_state : assert property (@(posedge ref_clk)
    soft_rst |=> state_reg == SGPW_IDLE && !rotate_reg)
    else $error("decoder or mapping not restored by reset");
  chk_rst_addr : assert property (@(posedge ref_clk)
    soft_rst |=> wr_addr_reg == 13'h0000)
    else $error("write address not cleared by reset");
endmodule
`default_nettype wire

// file: sgpw_host_model.sv
// Host model driving the serial link
`timescale 1ns/100ps
`default_nettype none
module sgpw_host_model (
  // Link pins
  output logic link_clk,
  output logic select_n,
  output logic data_cmd,
  output logic serial_data_line
);
  // Short low at start gives the receiver a real deselect edge
  initial begin
    link_clk = 1'b0;
    select_n = 1'b0;
    data_cmd = 1'b1;
    serial_data_line = 1'b0;
    #1 select_n = 1'b1;
  end
  // Fewer than 8 bits leaves a partial byte behind
  task automatic send(input logic dc, input logic [7:0] b, input int n);
    #13;
    select_n = 1'b0;
    data_cmd = dc;
    for (int i = 7; i > 7 - n; i--) begin
      #32 link_clk = 1'b1;
      serial_data_line = b[i];
      #32 link_clk = 1'b0;
    end
    #32 select_n = 1'b1;
    // Released lines show no stale value
    data_cmd = ~dc;
    serial_data_line = ~serial_data_line;
  endtask
endmodule
`default_nettype wire

// file: sgpw_tb_top.sv
// Self-checking bench for the pixel RAM writer
`timescale 1ns/100ps
`default_nettype none
module sgpw_tb_top;
  logic        ref_clk;
  logic        sys_rst;
  logic        reset_n;
  logic        interface_strap_0;
  logic        interface_strap_1;
  logic [12:0] scan_addr;
  wire         link_clk;
  wire         select_n;
  wire         data_cmd;
  wire         serial_data_line;
  logic [7:0]  scan_data_reg;
  logic        serial_mode_reg;
  logic        rotate_reg;
  logic [12:0] wr_addr_reg;
  logic [7:0]  mem [5120];
  int          cs, ce, rs, re, col, row, rot;
  int          bad_count, checked, cycles;

  sgpw_host_model hst_u (
    .link_clk(link_clk), .select_n(select_n),
    .data_cmd(data_cmd), .serial_data_line(serial_data_line));
  sgpw_top dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .select_n(select_n), .data_cmd(data_cmd),
    .serial_data_line(serial_data_line), .reset_n(reset_n),
    .interface_strap_0(interface_strap_0),
    .interface_strap_1(interface_strap_1), .scan_addr(scan_addr),
    .scan_data_reg(scan_data_reg), .serial_mode_reg(serial_mode_reg),
    .rotate_reg(rotate_reg), .wr_addr_reg(wr_addr_reg));

  always #4 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Generous ceiling: about 100 bytes at under 100 cycles each
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic por();
    cs = 0;
    ce = 63;
    rs = 0;
    re = 79;
    col = 0;
    row = 0;
    rot = 0;
  endtask

  // Fixed wait covers the crossing into the system domain
  task automatic put(input logic dc, input logic [7:0] b);
    hst_u.send(dc, b, 8);
    repeat (8) @(negedge ref_clk);
    if (dc) begin
      mem[row * 64 + col] = b;
      if (col == ce) begin
        col = cs;
        row = (row == re) ? rs : row + 1;
      end else begin
        col++;
      end
      chk("wr_addr", 13'(row * 64 + col), wr_addr_reg);
    end
  endtask

  task automatic win(input logic [7:0] c, input int a, input int b);
    put(1'b0, c);
    put(1'b0, 8'(a));
    put(1'b0, 8'(b));
    if (c == 8'h15) begin
      cs = a;
      ce = b;
      col = a;
    end else begin
      rs = a;
      re = b;
      row = a;
    end
    chk("win_ptr", 13'(row * 64 + col), wr_addr_reg);
  endtask

  task automatic scan(input int a);
    logic [7:0] e;
    @(negedge ref_clk) scan_addr = 13'(a);
    @(negedge ref_clk);
    e = rot ? {mem[5119 - a][3:0], mem[5119 - a][7:4]} : mem[a];
    chk("scan_data", {5'h00, e}, {5'h00, scan_data_reg});
  endtask

  initial begin
    void'($urandom(32'h0a0611e3));
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    reset_n = 1'b1;
    interface_strap_0 = 1'b0;
    interface_strap_1 = 1'b0;
    scan_addr = 13'h0000;
    por();
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("serial_mode", 13'h0001, {12'h000, serial_mode_reg});
    for (int i = 0; i < 66; i++) put(1'b1, 8'($urandom));
    for (int i = 0; i < 66; i += 13) scan(i);
    // Corner window crosses end column and end row
    win(8'h15, 62, 63);
    win(8'h75, 78, 79);
    repeat (5) put(1'b1, 8'($urandom));
    scan(5119);
    scan(78 * 64 + 62);
    // One byte window keeps rewriting one place
    win(8'h15, 5, 5);
    win(8'h75, 3, 3);
    put(1'b1, 8'h3c);
    put(1'b1, 8'hc3);
    scan(197);
    // Partial byte dropped on deselect
    hst_u.send(1'b1, 8'h5a, 5);
    put(1'b1, 8'h96);
    scan(197);
    put(1'b0, 8'h81);
    put(1'b0, 8'ha1);
    rot = 1;
    chk("rotate", 13'h0001, {12'h000, rotate_reg});
    scan(5119 - 197);
    put(1'b0, 8'ha0);
    rot = 0;
    chk("rotate", 13'h0000, {12'h000, rotate_reg});
    @(negedge ref_clk) interface_strap_1 = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("serial_mode", 13'h0000, {12'h000, serial_mode_reg});
    interface_strap_1 = 1'b0;
    reset_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    por();
    chk("rst_ptr", 13'h0000, wr_addr_reg);
    scan(197);
    put(1'b1, 8'h7e);
    scan(0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
